// ==== hdl/tss_fifo.sv ====
`default_nettype none

module tss_fifo
  import tss_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
    logic                        ready;
  } tss_fifo_state_t;

  tss_fifo_state_t s_reg;
  tss_fifo_state_t s_next;

  logic push;
  logic pop;

  assign out_valid_out = (s_reg.count != '0);
  assign out_data_out  = s_reg.mem[s_reg.rd_ptr];
  assign in_ready_out  = s_reg.ready;

  always_comb begin
    s_next = s_reg;
    push   = in_valid_in & s_reg.ready;
    pop    = out_ready_in & out_valid_out;
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = in_data_in;
      s_next.wr_ptr = (s_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = (s_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_reg.rd_ptr + 1'b1;
    end
    s_next.count = s_reg.count + CW'(push) - CW'(pop);
    // Ready is registered so the filler sees a clean level
    s_next.ready = (s_next.count != CW'(DEPTH));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : tss_fifo

`default_nettype wire

// ==== hdl/tss_serial_port.sv ====

`default_nettype none

module tss_serial_port
  import tss_pkg::*;
#(
  // Arbitrary identity value, not tied to any maker
  parameter logic [`TSS_WORD_BITS-1:0] ID_WORD    = 16'h5a5c,
  parameter int                        FIFO_DEPTH = `TSS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  // Serial pins from the host
  input  wire logic                     cs_n_in,
  input  wire logic                     serial_shift_clock_in,
  input  wire logic                     sio_in,
  output logic                          sio_out,
  output logic                          sio_oe_out,
  // Conversion results from the sensing front end
  input  wire logic                     conv_valid_in,
  input  wire logic [`TSS_TEMP_BITS-1:0] conv_data_in,
  output logic                          conv_ready_out,
  // Mode status
  output logic                          conv_run_out,
  output logic                          shutdown_out
);

  // ****************************************
  // Helper functions
  // ****************************************

  function automatic logic is_shutdown_cmd(input logic [`TSS_CMD_BITS-1:0] cmd);
    is_shutdown_cmd = (cmd == `TSS_CMD_SHUTDOWN);
  endfunction : is_shutdown_cmd

  function automatic logic [`TSS_WORD_BITS-1:0] frame_word(
    input logic                      in_shutdown,
    input logic [`TSS_WORD_BITS-1:0] temp
  );
    // Identity replaces temperature while shut down
    frame_word = in_shutdown ? ID_WORD : temp;
  endfunction : frame_word

  // ****************************************
  // State
  // ****************************************

  tss_state_t s_reg;
  tss_state_t s_next;

  logic                      sel_fall;
  logic                      sel_rise;
  logic                      sck_rise;
  logic                      sck_fall;
  logic                      fifo_valid;
  logic [`TSS_TEMP_BITS-1:0] fifo_data;
  logic                      fifo_pop;
  logic [`TSS_CMD_BITS-1:0]  cmd_last;
  logic                      mode_next;

  // ****************************************
  // Result buffer
  // ****************************************

  // Results queue here while a frame is open; between frames each one popped overwrites temp unless shut down, so only the last is kept
  tss_fifo #(
    .WIDTH (`TSS_TEMP_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_result_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (conv_valid_in),
    .in_data_in    (conv_data_in),
    .in_ready_out  (conv_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (fifo_pop)
  );

  // ****************************************
  // Next-state logic
  // ****************************************

  always_comb begin
    s_next    = s_reg;
    fifo_pop  = 1'b0;
    mode_next = s_reg.shutdown;

    // Three flops per pin; edges only look at the second and third stage
    s_next.cs.meta  = cs_n_in;
    s_next.cs.sync  = s_reg.cs.meta;
    s_next.cs.dly   = s_reg.cs.sync;
    s_next.sck.meta = serial_shift_clock_in;
    s_next.sck.sync = s_reg.sck.meta;
    s_next.sck.dly  = s_reg.sck.sync;
    s_next.sio.meta = sio_in;
    s_next.sio.sync = s_reg.sio.meta;
    s_next.sio.dly  = s_reg.sio.sync;

    sel_fall = s_reg.cs.dly & ~s_reg.cs.sync;
    sel_rise = ~s_reg.cs.dly & s_reg.cs.sync;
    sck_rise = ~s_reg.sck.dly & s_reg.sck.sync;
    sck_fall = s_reg.sck.dly & ~s_reg.sck.sync;

    // Command as it stands with the bit now being sampled
    cmd_last = {s_reg.cmd[`TSS_CMD_BITS-2:0], s_reg.sio.sync};

    if (s_reg.cs.sync) begin
      // Deselected: idle, pin released, counter cleared
      s_next.phase   = TSS_PH_IDLE;
      s_next.cnt     = '0;
      s_next.sio_oe  = 1'b0;
      s_next.sio_out = 1'b0;
      s_next.rx_seen = 1'b0;
      if (sel_rise && s_reg.rx_seen) begin
        // The byte held when select rises is acted upon if any command bit came in
        mode_next = is_shutdown_cmd(s_reg.cmd);
      end
      // Results only land between frames so a read never sees a torn word
      if (fifo_valid) begin
        fifo_pop = 1'b1;
        if (!mode_next) begin
          s_next.temp = {fifo_data, `TSS_DONE_FLAG, `TSS_UNDEF_BITS};
        end
      end
    end else if (sel_fall) begin
      // First bit is on the pin as soon as select is seen low
      s_next.phase   = TSS_PH_TX;
      s_next.cnt     = '0;
      s_next.word    = frame_word(s_reg.shutdown, s_reg.temp);
      s_next.sio_out = s_next.word[`TSS_WORD_BITS-1];
      s_next.sio_oe  = 1'b1;
      s_next.cmd     = '0;
      s_next.rx_seen = 1'b0;
    end else if (sck_rise) begin
      if (s_reg.phase == TSS_PH_RX) begin
        s_next.cmd     = cmd_last;
        s_next.rx_seen = 1'b1;
      end
      if (s_reg.cnt == `TSS_FRAME_LAST) begin
        // Frame complete with select still low: act and start another
        mode_next      = is_shutdown_cmd(cmd_last);
        s_next.phase   = TSS_PH_TX;
        s_next.cnt     = '0;
        s_next.word    = frame_word(mode_next, s_reg.temp);
        s_next.sio_out = s_next.word[`TSS_WORD_BITS-1];
        s_next.sio_oe  = 1'b1;
        s_next.cmd     = '0;
        s_next.rx_seen = 1'b0;
      end else begin
        s_next.cnt = s_reg.cnt + 5'd1;
        if (s_reg.cnt == `TSS_TX_LAST) begin
          s_next.phase = TSS_PH_RX;
        end
      end
    end else if (sck_fall) begin
      if (s_reg.phase == TSS_PH_TX) begin
        // No rise yet in this frame: a chained frame must keep D15 for the host
        if (s_reg.cnt != '0) begin
          // Next bit out on the falling edge, MSB first
          s_next.word    = {s_reg.word[`TSS_WORD_BITS-2:0], 1'b0};
          s_next.sio_out = s_reg.word[`TSS_WORD_BITS-2];
          // Lowest two bits are undefined, so the pin floats for them
          s_next.sio_oe  = (s_reg.cnt < `TSS_DRIVEN_BITS);
        end
      end else begin
        s_next.sio_oe  = 1'b0;
      end
    end

    s_next.shutdown = mode_next;
    s_next.conv_run = ~mode_next;
  end

  // ****************************************
  // State register
  // ****************************************

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '{
        cs:       '{meta: 1'b1, sync: 1'b1, dly: 1'b1},
        sck:      '{meta: 1'b0, sync: 1'b0, dly: 1'b0},
        sio:      '{meta: 1'b0, sync: 1'b0, dly: 1'b0},
        phase:    TSS_PH_IDLE,
        cnt:      '0,
        word:     '0,
        cmd:      '0,
        rx_seen:  1'b0,
        shutdown: 1'b0,
        conv_run: 1'b1,
        temp:     `TSS_TEMP_POR,
        sio_out:  1'b0,
        sio_oe:   1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign sio_out      = s_reg.sio_out;
  assign sio_oe_out   = s_reg.sio_oe;
  assign conv_run_out = s_reg.conv_run;
  assign shutdown_out = s_reg.shutdown;

endmodule : tss_serial_port

`default_nettype wire

// ==== shared/tss_pkg.sv ====
`default_nettype none

package tss_pkg;

`include "tss_regs.svh"

  // ****************************************
  // Transaction phase
  // ****************************************
  typedef enum logic [1:0] {
    TSS_PH_IDLE = 2'b00,
    TSS_PH_TX   = 2'b01,
    TSS_PH_RX   = 2'b10
  } tss_phase_t;

  // ****************************************
  // Pin synchroniser chain
  // ****************************************
  typedef struct packed {
    logic meta;
    logic sync;
    logic dly;
  } tss_pin_sync_t;

  // ****************************************
  // Complete state of the serial port
  // ****************************************
  typedef struct packed {
    tss_pin_sync_t                cs;
    tss_pin_sync_t                sck;
    tss_pin_sync_t                sio;
    tss_phase_t                   phase;
    logic [4:0]                   cnt;
    logic [`TSS_WORD_BITS-1:0]    word;
    logic [`TSS_CMD_BITS-1:0]     cmd;
    logic                         rx_seen;
    logic                         shutdown;
    logic                         conv_run;
    logic [`TSS_WORD_BITS-1:0]    temp;
    logic                         sio_out;
    logic                         sio_oe;
  } tss_state_t;

endpackage : tss_pkg

`default_nettype wire

// ==== shared/tss_regs.svh ====
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH

// ****************************************
// Frame geometry
// ****************************************
`define TSS_WORD_BITS    16
`define TSS_FRAME_LAST   5'd31
`define TSS_TX_LAST      5'd15
`define TSS_DRIVEN_BITS  5'd14
`define TSS_CMD_BITS     8

// ****************************************
// Register contents
// ****************************************
`define TSS_TEMP_BITS    13
`define TSS_TEMP_POR     16'hff00
`define TSS_DONE_FLAG    1'b1
`define TSS_UNDEF_BITS   2'b00
`define TSS_CMD_SHUTDOWN 8'hff
`define TSS_FIFO_DEPTH   4

`endif

// ==== verification/testbench.sv ====
`default_nettype none

`define CHK(g, e) check(32'(g), 32'(e))

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity value
  localparam logic [15:0] ID_VAL = 16'h5a5c;
  typedef struct packed {
    logic        push;
    logic [12:0] data;
    logic [15:0] cmd;
    logic [4:0]  nrx;
    logic [13:0] exp_rd;
    logic        exp_sd;
  } tss_row_t;
  tss_row_t rows [6] = '{
    '{1'b0, 13'h0000, 16'h0000, 5'h10, 14'h3fc0, 1'b0},
    '{1'b1, 13'h0190, 16'h0000, 5'h10, 14'h0321, 1'b0},
    '{1'b1, 13'h1c90, 16'h00ff, 5'h10, 14'h3921, 1'b1},
    '{1'b1, 13'h0001, 16'h0001, 5'h08, 14'h1697, 1'b0},
    '{1'b0, 13'h0000, 16'h000f, 5'h10, 14'h3921, 1'b0},
    '{1'b1, 13'h0960, 16'h0000, 5'h0c, 14'h12c1, 1'b0}};
  logic        clk_in, rst_in, cs_n, sck, sio_line, dut_out, dut_oe, h_out, h_oe;
  logic        valid, ready, run, sd;
  logic        float_reg = 1'b0;
  logic [12:0] data;
  logic [15:0] rd;
  logic [7:0]  code;
  int          err_total, n_checks;

  tss_serial_port #(.ID_WORD(ID_VAL), .FIFO_DEPTH(4)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .serial_shift_clock_in(sck), .sio_in(sio_line),
    .sio_out(dut_out), .sio_oe_out(dut_oe), .conv_valid_in(valid), .conv_data_in(data),
    .conv_ready_out(ready), .conv_run_out(run), .shutdown_out(sd));
  tss_host_model u_host (.cs_n_out(cs_n), .sck_out(sck), .sio_out(h_out), .sio_oe_out(h_oe), .sio_in(sio_line));

  // Released line shows the inverse of its last value, never a lucky match
  assign sio_line = dut_oe ? dut_out : (h_oe ? h_out : float_reg);
  always @* begin
    if (dut_oe || h_oe) float_reg = ~(dut_oe ? dut_out : h_out);
  end
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // ******
  // Tasks
  // ******
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic xfer(input logic [15:0] cmd, input int ntx, input int nrx);
    @(posedge clk_in);
    u_host.frame(cmd, ntx, nrx, rd);
  endtask : xfer
  task automatic push(input logic p, input logic [12:0] d);
    @(posedge clk_in);
    valid <= p;
    data  <= d;
    @(posedge clk_in);
    valid <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : push
  initial begin
    #200us;
    err_total++;
    tally_and_finish();
  end
  // ******
  // Sequence
  // ******
  initial begin
    rst_in <= 1'b1;
    valid  <= 1'b0;
    data   <= 13'h0000;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK({run, sd, ready, dut_oe}, 4'ha);
    for (int r = 0; r < 6; r++) begin
      push(rows[r].push, rows[r].data);
      xfer(rows[r].cmd, 16, int'(rows[r].nrx));
      `CHK(rd[15:2], rows[r].exp_rd);
      `CHK(sd, rows[r].exp_sd);
    end
    for (int k = 0; k < 9; k++) begin
      code = 8'((9'h001 << k) - 9'h001);
      xfer({8'h00, code}, 16, 8);
      `CHK(sd, code == 8'hff);
    end
    xfer(16'h0000, 5, 0);
    `CHK({sd, rd[15:11]}, {1'b1, ID_VAL[15:11]});
    xfer(16'h0000, 16, 16);
    `CHK({sd, rd[15:2]}, {1'b0, ID_VAL[15:2]});
    // Results pile up while a frame is held open
    @(posedge clk_in);
    u_host.cs_n_out <= 1'b0;
    // Let select pass the synchroniser so no result is popped early
    repeat (3) @(posedge clk_in);
    valid <= 1'b1;
    data  <= 13'h00a0;
    repeat (8) begin
      @(posedge clk_in);
      if (ready) data <= data + 13'h0001;
    end
    `CHK(ready, 1'b0);
    valid <= 1'b0;
    u_host.cs_n_out <= 1'b1;
    repeat (10) @(posedge clk_in);
    `CHK(ready, 1'b1);
    xfer(16'h0000, 16, 16);
    `CHK(rd[15:2], {13'h00a3, 1'b1});
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire

// ==== verification/tss_host_model.sv ====
`default_nettype none

module tss_host_model (
  // Serial pins
  output logic     cs_n_out,
  output logic     sck_out,
  output logic     sio_out,
  output logic     sio_oe_out,
  input wire logic sio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_out   = 1'b1;
    sck_out    = 1'b0;
    sio_out    = 1'b0;
    sio_oe_out = 1'b0;
  end
  // ******
  // One frame; clock idles low so select never falls on a rise
  // ******
  task automatic frame(input logic [15:0] cmd, input int ntx, input int nrx, output logic [15:0] rd);
    rd = 16'h0000;
    #1.3;
    cs_n_out = 1'b0;
    #100;
    for (int i = 0; i < ntx + nrx; i++) begin
      sio_oe_out = (i >= 16);
      sio_out = cmd[4'(nrx + 15 - i)];
      #24;
      sck_out = 1'b1;
      if (i < 16) rd[4'(15 - i)] = sio_in;
      #24;
      sck_out = 1'b0;
    end
    #24;
    sio_oe_out = 1'b0;
    cs_n_out = 1'b1;
    #60;
  endtask : frame
endmodule : tss_host_model

`default_nettype wire

// ==== verification/tss_serial_port_sva.sv ====
`default_nettype none

module tss_serial_port_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins and mode
  input wire logic cs_n_in,
  input wire logic serial_shift_clock_in,
  input wire logic sio_in,
  input wire logic sio_out,
  input wire logic sio_oe_out,
  input wire logic conv_run_out,
  input wire logic shutdown_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // Raw pin tracking, a few clocks ahead of the synchronisers
  // ******
  logic       sck_reg;
  logic       cs_reg;
  logic       rx_reg;
  logic [4:0] cnt_reg;
  logic [7:0] sh_reg;
  wire        rise = serial_shift_clock_in & ~sck_reg;
  always_ff @(posedge clk_in) begin
    sck_reg <= serial_shift_clock_in;
    cs_reg  <= cs_n_in;
    if (rst_in || (cs_reg && !cs_n_in)) begin
      sh_reg <= 8'h00;
      rx_reg <= 1'b0;
    end else if (rise && !cs_n_in && cnt_reg >= 5'h10) begin
      sh_reg <= {sh_reg[6:0], sio_in};
      rx_reg <= 1'b1;
    end
    if (rst_in || cs_n_in) begin
      cnt_reg <= 5'h00;
    end else if (rise) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
  // ******
  // Properties
  // ******
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_idle;
    cs_n_in [*5];
  endsequence
  sequence s_body;
    (!cs_n_in && cnt_reg == 5'h03) [*5];
  endsequence
  sequence s_tail;
    (!cs_n_in && cnt_reg == 5'h0f) [*5];
  endsequence
  AST_IDLE_FLOAT: assert property (s_idle |-> !sio_oe_out)
    else $error("pin driven while idle");
  AST_FIRST_BIT: assert property ($fell(cs_n_in) |-> ##[1:4] sio_oe_out)
    else $error("first bit late");
  AST_BODY: assert property (s_body |-> sio_oe_out)
    else $error("pin released early");
  AST_TAIL: assert property (s_tail |-> !sio_oe_out)
    else $error("pin held past bit 14");
  AST_SHIFT: assert property ($changed(sio_out) && sio_oe_out && !cs_n_in && cnt_reg != 5'h00 |-> !$past(serial_shift_clock_in, 2))
    else $error("bit changed off falling edge");
  AST_POR_MODE: assert property ($fell(rst_in) |-> conv_run_out && !shutdown_out)
    else $error("wrong mode after reset");
  AST_MODE_HOLD: assert property (cs_n_in [*8] |-> $stable(shutdown_out))
    else $error("mode moved while idle");
  AST_DECODE: assert property ($rose(cs_n_in) && rx_reg |-> ##6 shutdown_out == (sh_reg == 8'hff))
    else $error("command decoded wrongly");
endmodule : tss_serial_port_sva

bind tss_serial_port tss_serial_port_sva u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .serial_shift_clock_in(serial_shift_clock_in),
  .sio_in(sio_in), .sio_out(sio_out), .sio_oe_out(sio_oe_out), .conv_run_out(conv_run_out),
  .shutdown_out(shutdown_out));

`default_nettype wire
